/* File: rtl/sru_pkg.sv */
// Package: constants, opcodes and bus carriers of the stack/rotate unit
package sru_pkg;

	// Bus register byte offsets
	localparam logic [7:0] OFF_CMD      = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_FLAGS    = 8'h08;
	localparam logic [7:0] OFF_STACK    = 8'h0c;
	localparam logic [7:0] OFF_COUNTER  = 8'h10;
	localparam logic [7:0] OFF_GROUP    = 8'h14;
	localparam logic [7:0] OFF_MEM_ADDR = 8'h18;
	localparam logic [7:0] OFF_MEM_DATA = 8'h1c;

	// Status bit positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_ERR  = 1;

	// Register-file addresses of the control registers
	localparam logic [7:0] ADDR_FLAGS    = 8'hfc;
	localparam logic [7:0] ADDR_GROUP    = 8'hfd;
	localparam logic [7:0] ADDR_STACK_HI = 8'hfe;
	localparam logic [7:0] ADDR_STACK_LO = 8'hff;

	// Working-register escape nibble
	localparam logic [3:0] WR_NIBBLE = 4'he;

	// Opcodes; indirect forms set bit 0
	localparam logic [7:0] OP_PUSH_R    = 8'h70;
	localparam logic [7:0] OP_PUSH_IND  = 8'h71;
	localparam logic [7:0] OP_CARRY_CLR = 8'hcf;
	localparam logic [7:0] OP_RETURN    = 8'haf;
	localparam logic [7:0] OP_ROT_L     = 8'h80;
	localparam logic [7:0] OP_ROT_LC    = 8'h10;
	localparam logic [7:0] OP_ROT_R     = 8'he0;
	localparam logic [7:0] OP_ROT_RC    = 8'hc0;

	// Flag bit positions inside the flag register
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;
	localparam int FLAG_D = 3;
	localparam int FLAG_H = 2;

	// Reset values
	localparam logic [15:0] STACK_RESET   = 16'h0000;
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [7:0]  FLAGS_RESET   = 8'h00;
	localparam logic [7:0]  GROUP_RESET   = 8'h00;

	// Register file depth
	localparam int RF_DEPTH = 256;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

endpackage

/* File: rtl/sru_regfile.sv */
// Register file memory with registered read data
`timescale 1ns/10ps
module sru_regfile import sru_pkg::*; (
	input  wire logic       sys_clk_i,
	input  wire logic       we_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);

	logic [7:0] mem [RF_DEPTH];

	// Single port; a read during a write returns the old byte
	always_ff @(posedge sys_clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end

endmodule

/* File: rtl/stack_return_rotate_unit.sv */
// Stack push, return, carry-clear and rotate datapath with APB registers
`timescale 1ns/10ps
module stack_return_rotate_unit import sru_pkg::*; (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire apb_req_t    apb_i,
	output apb_rsp_t         apb_o,
	output logic             busy_o,
	output logic             fetch_o,
	output logic      [15:0] fetch_addr_o
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_PTR_RD, ST_PTR_USE, ST_OP_RD, ST_OP_USE,
		ST_RTN_HI_RD, ST_RTN_HI_USE, ST_RTN_LO_RD, ST_RTN_LO_USE
	} state_t;

	state_t      state;
	logic [7:0]  opcode;
	logic [7:0]  addr;
	logic [7:0]  flags;
	logic [7:0]  working_group_pointer;
	logic [15:0] stack_pointer;
	logic [15:0] program_counter;
	logic [7:0]  mem_ptr;
	logic        err;
	logic        mem_rd_pend;
	logic [7:0]  rd_val;
	logic [7:0]  rot_res;
	logic        rot_c;
	logic        exec_we;
	logic [7:0]  exec_waddr;
	logic [7:0]  exec_wdata;
	logic [7:0]  next_flags;
	logic [7:0]  mem_addr;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic        mem_we;
	logic [15:0] stack_dec;
	logic        setup;
	logic        wr_fire;
	logic        cmd_fire;

	function automatic logic [7:0] op_base(input logic [7:0] op);
		return {op[7:1], 1'b0};
	endfunction

	function automatic logic is_push(input logic [7:0] op);
		return op_base(op) == OP_PUSH_R;
	endfunction

	function automatic logic is_rot(input logic [7:0] op);
		return op_base(op) == OP_ROT_L || op_base(op) == OP_ROT_LC ||
			op_base(op) == OP_ROT_R || op_base(op) == OP_ROT_RC;
	endfunction

	function automatic logic is_ctrl(input logic [7:0] a);
		return a[7:2] == ADDR_FLAGS[7:2];
	endfunction

	// Short working-register form maps into the selected group
	function automatic logic [7:0] resolve(input logic [7:0] b,
			input logic [7:0] grp);
		return (b[7:4] == WR_NIBBLE) ? {grp[7:4], b[3:0]} : b;
	endfunction

	// Returns {carry, result}
	function automatic logic [8:0] rotate(input logic [7:0] op,
			input logic [7:0] v, input logic c);
		unique case (op_base(op))
			OP_ROT_L:  rotate = {v[7], v[6:0], v[7]};
			OP_ROT_LC: rotate = {v[7], v[6:0], c};
			OP_ROT_R:  rotate = {v[0], v[0], v[7:1]};
			default:   rotate = {v[0], c, v[7:1]};
		endcase
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return a[1:0] == 2'b00 && a <= OFF_MEM_DATA;
	endfunction

	// Refuse unmapped offsets, and writes other than to status and memory-data reads while executing
	function automatic logic refuse(input apb_req_t r, input logic bz);
		if (!addr_ok(r.paddr))
			return 1'b1;
		if (bz && r.pwrite && r.paddr != OFF_STATUS)
			return 1'b1;
		return bz && !r.pwrite && r.paddr == OFF_MEM_DATA;
	endfunction

	assign stack_dec = stack_pointer - 16'h0001;
	assign setup     = apb_i.psel && !apb_i.penable;
	assign wr_fire   = apb_i.psel && apb_i.penable && apb_o.pready &&
		apb_i.pwrite && !apb_o.pslverr;
	assign cmd_fire  = wr_fire && apb_i.paddr == OFF_CMD;

	// Operand fetch, rotation and the write-back of the executing step
	always_comb begin
		unique case (addr)
			ADDR_FLAGS:    rd_val = flags;
			ADDR_GROUP:    rd_val = working_group_pointer;
			ADDR_STACK_HI: rd_val = stack_pointer[15:8];
			ADDR_STACK_LO: rd_val = stack_pointer[7:0];
			default:       rd_val = mem_rdata;
		endcase
		{rot_c, rot_res} = rotate(opcode, rd_val, flags[FLAG_C]);
		exec_we    = state == ST_OP_USE;
		exec_waddr = is_push(opcode) ? stack_dec[7:0] : addr;
		exec_wdata = is_push(opcode) ? rd_val : rot_res;
		next_flags = flags;
		next_flags[FLAG_C] = rot_c;
		next_flags[FLAG_Z] = rot_res == 8'h00;
		next_flags[FLAG_S] = rot_res[7];
		next_flags[FLAG_V] = rot_res[7] ^ rd_val[7];
	end

	// The engine owns the memory port while busy
	assign mem_we    = busy_o ? exec_we && !is_ctrl(exec_waddr) :
		wr_fire && apb_i.paddr == OFF_MEM_DATA;
	assign mem_addr  = busy_o ? (exec_we ? exec_waddr : addr) : mem_ptr;
	assign mem_wdata = busy_o ? exec_wdata : apb_i.pwdata[7:0];

	sru_regfile sru_regfile_inst (
		.sys_clk_i (sys_clk_i),
		.we_i      (mem_we),
		.addr_i    (mem_addr),
		.wdata_i   (mem_wdata),
		.rdata_o   (mem_rdata)
	);

	// Sequencer; each read step waits one cycle for the memory
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state  <= ST_IDLE;
			busy_o <= 1'b0;
			opcode <= 8'h00;
			addr   <= 8'h00;
		end else begin
			unique case (state)
				ST_IDLE: if (cmd_fire) begin
					opcode <= apb_i.pwdata[7:0];
					if (apb_i.pwdata[7:0] == OP_RETURN) begin
						addr   <= stack_pointer[7:0];
						state  <= ST_RTN_HI_RD;
						busy_o <= 1'b1;
					end else if (is_push(apb_i.pwdata[7:0]) ||
							is_rot(apb_i.pwdata[7:0])) begin
						addr   <= resolve(apb_i.pwdata[15:8],
							working_group_pointer);
						state  <= apb_i.pwdata[0] ? ST_PTR_RD : ST_OP_RD;
						busy_o <= 1'b1;
					end
				end
				ST_PTR_RD: state <= ST_PTR_USE;
				ST_PTR_USE: begin
					addr  <= rd_val;
					state <= ST_OP_RD;
				end
				ST_OP_RD: state <= ST_OP_USE;
				ST_OP_USE: begin
					state  <= ST_IDLE;
					busy_o <= 1'b0;
				end
				ST_RTN_HI_RD: state <= ST_RTN_HI_USE;
				ST_RTN_HI_USE: begin
					addr  <= stack_pointer[7:0] + 8'h01;
					state <= ST_RTN_LO_RD;
				end
				ST_RTN_LO_RD: state <= ST_RTN_LO_USE;
				ST_RTN_LO_USE: begin
					state  <= ST_IDLE;
					busy_o <= 1'b0;
				end
			endcase
		end
	end

	// Flags; a rotate's own update beats the write-back of its result to FC
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			flags <= FLAGS_RESET;
		end else if (exec_we && is_rot(opcode)) begin
			flags <= next_flags;
		end else if (cmd_fire && apb_i.pwdata[7:0] == OP_CARRY_CLR) begin
			flags[FLAG_C] <= 1'b0;
		end else if (exec_we && exec_waddr == ADDR_FLAGS) begin
			flags <= exec_wdata;
		end else if (wr_fire && apb_i.paddr == OFF_FLAGS) begin
			flags <= apb_i.pwdata[7:0];
		end
	end

	// Stack pointer; push and return arithmetic beat byte writes
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			stack_pointer <= STACK_RESET;
		end else if (exec_we && is_push(opcode)) begin
			stack_pointer <= stack_dec;
		end else if (state == ST_RTN_LO_USE) begin
			stack_pointer <= stack_pointer + 16'h0002;
		end else if (exec_we && exec_waddr == ADDR_STACK_HI) begin
			stack_pointer[15:8] <= exec_wdata;
		end else if (exec_we && exec_waddr == ADDR_STACK_LO) begin
			stack_pointer[7:0] <= exec_wdata;
		end else if (wr_fire && apb_i.paddr == OFF_STACK) begin
			stack_pointer <= apb_i.pwdata[15:0];
		end
	end

	// Program counter and the refetch request after a return
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			program_counter <= COUNTER_RESET;
			fetch_o         <= 1'b0;
			fetch_addr_o    <= COUNTER_RESET;
		end else begin
			fetch_o <= state == ST_RTN_LO_USE;
			if (state == ST_RTN_HI_USE) begin
				program_counter[15:8] <= rd_val;
			end else if (state == ST_RTN_LO_USE) begin
				program_counter[7:0] <= rd_val;
				fetch_addr_o <= {program_counter[15:8], rd_val};
			end else if (wr_fire && apb_i.paddr == OFF_COUNTER) begin
				program_counter <= apb_i.pwdata[15:0];
			end
		end
	end

	// Working group pointer
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			working_group_pointer <= GROUP_RESET;
		end else if (exec_we && exec_waddr == ADDR_GROUP) begin
			working_group_pointer <= exec_wdata;
		end else if (wr_fire && apb_i.paddr == OFF_GROUP) begin
			working_group_pointer <= apb_i.pwdata[7:0];
		end
	end

	// Bus-side memory pointer and sticky bad-opcode flag; set wins
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			mem_ptr <= 8'h00;
			err     <= 1'b0;
		end else begin
			if (wr_fire && apb_i.paddr == OFF_MEM_ADDR) begin
				mem_ptr <= apb_i.pwdata[7:0];
			end
			if (cmd_fire && apb_i.pwdata[7:0] != OP_CARRY_CLR &&
					apb_i.pwdata[7:0] != OP_RETURN &&
					!is_push(apb_i.pwdata[7:0]) &&
					!is_rot(apb_i.pwdata[7:0])) begin
				err <= 1'b1;
			end else if (wr_fire && apb_i.paddr == OFF_STATUS &&
					apb_i.pwdata[STAT_ERR]) begin
				err <= 1'b0;
			end
		end
	end

	// APB answer; memory reads take one wait state for the RAM
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			apb_o       <= '0;
			mem_rd_pend <= 1'b0;
		end else begin
			apb_o.pready <= 1'b0;
			mem_rd_pend  <= 1'b0;
			if (setup && !apb_i.pwrite && !busy_o &&
					apb_i.paddr == OFF_MEM_DATA) begin
				mem_rd_pend <= 1'b1;
			end else if (mem_rd_pend) begin
				apb_o.pready  <= 1'b1;
				apb_o.pslverr <= 1'b0;
				apb_o.prdata  <= {24'h000000, mem_rdata};
			end else if (setup) begin
				apb_o.pready  <= 1'b1;
				apb_o.pslverr <= refuse(apb_i, busy_o);
				apb_o.prdata  <= 32'h00000000;
				if (!apb_i.pwrite) begin
					unique case (apb_i.paddr)
						OFF_CMD:      apb_o.prdata[15:0] <= {addr, opcode};
						OFF_STATUS:   apb_o.prdata[1:0] <= {err, busy_o};
						OFF_FLAGS:    apb_o.prdata[7:0] <= flags;
						OFF_STACK:    apb_o.prdata[15:0] <= stack_pointer;
						OFF_COUNTER:  apb_o.prdata[15:0] <= program_counter;
						OFF_GROUP:    apb_o.prdata[7:0] <= working_group_pointer;
						OFF_MEM_ADDR: apb_o.prdata[7:0] <= mem_ptr;
						default:      apb_o.prdata <= 32'h00000000;
					endcase
				end
			end
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence push_direct_walk;
		state == ST_OP_RD ##1 state == ST_OP_USE ##1 state == ST_IDLE;
	endsequence

	sequence return_walk;
		state == ST_RTN_HI_RD ##1 state == ST_RTN_HI_USE ##1
		state == ST_RTN_LO_RD ##1 state == ST_RTN_LO_USE;
	endsequence

	a_push_sp_dec: assert property (
		exec_we && is_push(opcode) |-> mem_addr == stack_dec[7:0] ##1
		stack_pointer == $past(stack_pointer) - 16'h0001)
		else $error("push did not predecrement the stack pointer");

	a_push_decode: assert property (
		cmd_fire && apb_i.pwdata[7:0] == OP_PUSH_R |=> push_direct_walk)
		else $error("direct push did not take the direct path");

	a_push_indirect: assert property (
		cmd_fire && apb_i.pwdata[7:0] == OP_PUSH_IND |=>
		state == ST_PTR_RD ##1 state == ST_PTR_USE ##1 push_direct_walk)
		else $error("indirect push did not fetch its pointer");

	a_push_flags: assert property (
		exec_we && is_push(opcode) && addr == ADDR_FLAGS |->
		exec_wdata == flags ##1 flags == $past(flags))
		else $error("push of the flag address mishandled flags");

	a_working_map: assert property (
		cmd_fire && is_rot(apb_i.pwdata[7:0]) &&
		apb_i.pwdata[15:12] == WR_NIBBLE |=>
		addr == {working_group_pointer[7:4], $past(apb_i.pwdata[11:8])})
		else $error("working register not mapped into its group");

	a_carry_clear: assert property (
		cmd_fire && apb_i.pwdata[7:0] == OP_CARRY_CLR |=> !flags[FLAG_C] &&
		flags[6:0] == $past(flags[6:0]) && !busy_o)
		else $error("carry clear wrong");

	a_return_walk: assert property (
		state == ST_RTN_HI_RD |-> return_walk ##1
		(stack_pointer == $past(stack_pointer, 4) + 16'h0002 &&
		fetch_o && fetch_addr_o == program_counter &&
		flags == $past(flags, 4)))
		else $error("return sequence wrong");

	a_return_bytes: assert property (
		state == ST_RTN_HI_USE |-> addr == stack_pointer[7:0] ##1
		program_counter[15:8] == $past(rd_val) &&
		addr == stack_pointer[7:0] + 8'h01)
		else $error("return high byte not from the stack top");

	a_rot_carry: assert property (
		exec_we && is_rot(opcode) |=> flags[FLAG_C] ==
		($past(opcode[6]) ? $past(rd_val[0]) : $past(rd_val[7])))
		else $error("rotate carry from the wrong end");

	// Left rotates have opcode bit 6 clear; bit 5 marks the plain right
	a_rot_fill: assert property (
		exec_we && is_rot(opcode) |-> (!opcode[6] ?
		(rot_res[7:1] == rd_val[6:0] && rot_res[0] ==
		(opcode[7] ? rd_val[7] : flags[FLAG_C])) :
		(rot_res[6:0] == rd_val[7:1] && rot_res[7] ==
		(opcode[5] ? rd_val[0] : flags[FLAG_C]))))
		else $error("rotate fill bit wrong");

	a_rot_zs: assert property (
		exec_we && is_rot(opcode) |=>
		flags[FLAG_Z] == ($past(exec_wdata) == 8'h00) &&
		flags[FLAG_S] == $past(exec_wdata[7]))
		else $error("rotate zero or sign flag wrong");

	a_rot_overflow: assert property (
		exec_we && is_rot(opcode) |=> flags[FLAG_V] ==
		($past(rd_val[7]) ^ $past(exec_wdata[7])) &&
		flags[3:0] == $past(flags[3:0]))
		else $error("rotate overflow or kept flags wrong");

endmodule

/* File: dv/tb_stack_return_rotate_unit.sv */
// Self-checking bench for the stack, return and rotate datapath
`timescale 1ns/10ps
module tb_stack_return_rotate_unit import sru_pkg::*;;
	logic        sys_clk_i;
	logic        rst_n_i;
	apb_req_t    apb_i;
	apb_rsp_t    apb_o;
	logic        busy_o;
	logic        fetch_o;
	logic [15:0] fetch_addr_o;
	logic [31:0] q;
	logic        e;
	int          n_errors;
	int          n_tests;
	logic [7:0]  ops [4];
	logic [7:0]  vals [3];

	stack_return_rotate_unit stack_return_rotate_unit_inst (
		.sys_clk_i    (sys_clk_i),
		.rst_n_i      (rst_n_i),
		.apb_i        (apb_i),
		.apb_o        (apb_o),
		.busy_o       (busy_o),
		.fetch_o      (fetch_o),
		.fetch_addr_o (fetch_addr_o)
	);

	// Free-running 250 MHz clock
	always #2 sys_clk_i = ~sys_clk_i;

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic hang(input string msg);
		$display("mismatch at %0t: %s", $time, msg);
		n_errors++;
		print_verdict();
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
			input string msg);
		n_tests++;
		if (got !== exp) begin
			$display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
			n_errors++;
		end
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic xfer(input logic [7:0] a, input logic w,
			input logic [31:0] d);
		int n;
		@(posedge sys_clk_i);
		apb_i.psel    <= 1'b1;
		apb_i.penable <= 1'b0;
		apb_i.paddr   <= a;
		apb_i.pwrite  <= w;
		apb_i.pwdata  <= d;
		@(posedge sys_clk_i);
		apb_i.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (apb_o.pready !== 1'b1 && n < 20);
		if (apb_o.pready !== 1'b1) hang("no pready");
		q = apb_o.prdata;
		e = apb_o.pslverr;
		apb_i.psel    <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a);
		xfer(a, 1'b0, 32'h0);
	endtask

	task automatic wr_mem(input logic [7:0] a, input logic [7:0] v);
		wr(OFF_MEM_ADDR, {24'h0, a});
		wr(OFF_MEM_DATA, {24'h0, v});
	endtask

	task automatic rd_mem(input logic [7:0] a);
		wr(OFF_MEM_ADDR, {24'h0, a});
		rd(OFF_MEM_DATA);
	endtask

	// Poll status; a stuck busy ends the run
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			rd(OFF_STATUS);
			n++;
		end while (q[STAT_BUSY] !== 1'b0 && n < 30);
		if (q[STAT_BUSY] !== 1'b0) hang("busy never fell");
	endtask

	task automatic reset_values();
		logic [7:0] regs [5];
		regs = '{OFF_FLAGS, OFF_STACK, OFF_COUNTER, OFF_GROUP, OFF_STATUS};
		foreach (regs[i]) begin
			rd(regs[i]);
			chk(q[15:0], 16'h0, "reset value");
		end
		chk({14'h0, busy_o, fetch_o}, 16'h0, "outputs after reset");
		rd(8'h20);
		chk({15'h0, e}, 16'h1, "unmapped read error");
		// An undecoded opcode must raise the sticky error bit
		wr(OFF_CMD, 32'h00000001);
		rd(OFF_STATUS);
		chk(q[15:0], 16'h0002, "bad opcode flagged");
		wr(OFF_STATUS, 32'h00000002);
		rd(OFF_STATUS);
		chk(q[15:0], 16'h0000, "bad opcode cleared");
	endtask

	// Operand E6 or E4 lands in group 3 because the pointer holds 30
	task automatic do_rot(input logic [7:0] op, input logic [7:0] v,
			input logic cin, input logic ind);
		logic [7:0] r;
		logic [7:0] f;
		logic [7:0] t;
		logic       c;
		f = {cin, 3'b101, 4'b1101};
		case (op)
			OP_ROT_L:  r = {v[6:0], v[7]};
			OP_ROT_LC: r = {v[6:0], cin};
			OP_ROT_R:  r = {v[0], v[7:1]};
			default:   r = {cin, v[7:1]};
		endcase
		c = (op == OP_ROT_L || op == OP_ROT_LC) ? v[7] : v[0];
		t = ind ? 8'hc6 : 8'h36;
		wr(OFF_GROUP, 32'h30);
		wr_mem(8'h34, 8'hc6);
		wr_mem(t, v);
		wr(OFF_FLAGS, {24'h0, f});
		wr(OFF_CMD, {16'h0, (ind ? 8'he4 : 8'he6), op | {7'h0, ind}});
		wait_idle();
		rd_mem(t);
		chk(q[15:0], {8'h0, r}, "rotate result");
		rd(OFF_FLAGS);
		chk(q[15:0], {8'h0, c, r == 8'h00, r[7], v[7] ^ r[7], f[3:0]},
			"rotate flags");
	endtask

	task automatic push_test();
		wr(OFF_STACK, 32'h1001);
		wr(OFF_FLAGS, 32'ha5);
		wr(OFF_CMD, {16'h0, ADDR_FLAGS, OP_PUSH_R});
		wait_idle();
		rd(OFF_STACK);
		chk(q[15:0], 16'h1000, "push pointer");
		rd_mem(8'h00);
		chk(q[15:0], 16'h00a5, "pushed flag byte");
		wr(OFF_STACK, 32'h0061);
		wr(OFF_GROUP, 32'h30);
		wr_mem(8'h34, ADDR_FLAGS);
		wr(OFF_CMD, {16'h0, 8'he4, OP_PUSH_IND});
		// Busy shows one edge after the command; a write then is refused
		@(posedge sys_clk_i);
		chk({15'h0, busy_o}, 16'h1, "busy during push");
		wr(OFF_FLAGS, 32'h00);
		chk({15'h0, e}, 16'h1, "write refused while busy");
		wait_idle();
		rd(OFF_STACK);
		chk(q[15:0], 16'h0060, "indirect push pointer");
		rd_mem(8'h60);
		chk(q[15:0], 16'h00a5, "indirect pushed byte");
		rd(OFF_FLAGS);
		chk(q[15:0], 16'h00a5, "push keeps flags");
	endtask

	task automatic return_test();
		int n;
		wr(OFF_STACK, 32'h2000);
		wr_mem(8'h00, 8'h18);
		wr_mem(8'h01, 8'hb5);
		wr(OFF_FLAGS, 32'h5a);
		wr(OFF_CMD, {24'h0, OP_RETURN});
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (fetch_o !== 1'b1 && n < 20);
		if (fetch_o !== 1'b1) hang("no refetch pulse");
		chk(fetch_addr_o, 16'h18b5, "refetch address");
		@(posedge sys_clk_i);
		chk({15'h0, fetch_o}, 16'h0, "refetch pulse width");
		wait_idle();
		rd(OFF_STACK);
		chk(q[15:0], 16'h2002, "return pointer");
		rd(OFF_COUNTER);
		chk(q[15:0], 16'h18b5, "return counter");
		rd(OFF_FLAGS);
		chk(q[15:0], 16'h005a, "return keeps flags");
	endtask

	// Carry cleared from both prior values, nothing else touched
	task automatic carry_clear_test();
		wr(OFF_FLAGS, 32'hff);
		wr(OFF_CMD, {24'h0, OP_CARRY_CLR});
		rd(OFF_FLAGS);
		chk(q[15:0], 16'h007f, "carry clear from one");
		wr(OFF_FLAGS, 32'h7e);
		wr(OFF_CMD, {24'h0, OP_CARRY_CLR});
		rd(OFF_FLAGS);
		chk(q[15:0], 16'h007e, "carry clear from zero");
	endtask

	initial begin
		sys_clk_i = 1'b0;
		rst_n_i   = 1'b0;
		apb_i     = '0;
		n_errors  = 0;
		n_tests   = 0;
		ops  = '{OP_ROT_L, OP_ROT_LC, OP_ROT_R, OP_ROT_RC};
		vals = '{8'h88, 8'h80, 8'h01};
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		reset_values();
		carry_clear_test();
		push_test();
		return_test();
		for (int ind = 0; ind < 2; ind++) begin
			foreach (ops[i]) begin
				foreach (vals[j]) begin
					do_rot(ops[i], vals[j], j == 2, ind[0]);
				end
			end
		end
		print_verdict();
	end
endmodule
